/* core/hole_count_shear_trigger.sv */
`timescale 1ns/1ps
`include "hole_shear_defines.svh"

module hole_count_shear_trigger #(
  parameter int DW = 24,
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hole_in,
  input wire logic enc_step,
  input wire logic shear_done,
  output logic line_run,
  output logic shear_req,
  output logic irq
);

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  hole_shear_pkg::cut_mode_t mode;
  hole_shear_pkg::hole_pol_t pol;
  logic [DW-1:0] part_length;
  logic [CW-1:0] hole_target;
  logic [DW-1:0] cut_offset;
  logic [DW-1:0] shear_det;
  logic [DW-1:0] min_spacing;
  logic [DW-1:0] no_hole_stop;
  logic [CW-1:0] part_quantity;
  logic [`HS_EVT_COUNT-1:0] irq_mask;

  // ------------------------------------------------------------
  // run state
  // ------------------------------------------------------------
  hole_shear_pkg::line_state_t state;
  hole_shear_pkg::line_state_t next_state;
  logic [DW-1:0] pos_since_cut;
  logic [DW-1:0] dist_since_hole;
  logic hole_seen;
  logic [CW-1:0] holes;
  logic [CW-1:0] parts;
  logic fault;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic mapped;
  logic start_pulse;
  logic stop_pulse;
  logic clr_fault_pulse;
  logic irq_rd_clr;
  logic [`HS_EVT_COUNT-1:0] irq_status;
  logic [`HS_EVT_COUNT-1:0] evt_set;
  logic [31:0] rd_mux;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready = 1'b1;

  // unmapped offsets answer with an error, writes to them are dropped
  always_comb begin
    case (paddr)
      `HS_OFF_CTRL, `HS_OFF_PART_LENGTH, `HS_OFF_HOLE_TARGET, `HS_OFF_CUT_OFFSET,
      `HS_OFF_SHEAR_DET, `HS_OFF_MIN_SPACING, `HS_OFF_NO_HOLE_STOP, `HS_OFF_PART_QUANTITY,
      `HS_OFF_STATUS, `HS_OFF_IRQ_STATUS, `HS_OFF_IRQ_MASK, `HS_OFF_POSITION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access_ph & ~mapped;
  assign wr_en = access_ph & pwrite & mapped;

  // command bits of the control word act as one-cycle strobes
  assign start_pulse = wr_en & (paddr == `HS_OFF_CTRL) & pwdata[`HS_CTRL_START_BIT];
  assign stop_pulse = wr_en & (paddr == `HS_OFF_CTRL) & pwdata[`HS_CTRL_STOP_BIT];
  assign clr_fault_pulse = wr_en & (paddr == `HS_OFF_CTRL) & pwdata[`HS_CTRL_CLR_FAULT_BIT];
  assign irq_rd_clr = access_ph & ~pwrite & (paddr == `HS_OFF_IRQ_STATUS);

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // mode and polarity; polarity defaults to active-low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= hole_shear_pkg::cut_mode_t'(`HS_RST_MODE);
      pol <= hole_shear_pkg::hole_pol_t'(`HS_RST_POL);
    end else if (wr_en && paddr == `HS_OFF_CTRL) begin
      mode <= hole_shear_pkg::cut_mode_t'(pwdata[`HS_CTRL_MODE_BIT]);
      pol <= hole_shear_pkg::hole_pol_t'(pwdata[`HS_CTRL_POL_BIT]);
    end
  end

  // distances and counts; changes while running take effect at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_length <= '0;
      hole_target <= '0;
      cut_offset <= '0;
      shear_det <= '0;
      min_spacing <= '0;
      no_hole_stop <= '0;
      part_quantity <= '0;
      irq_mask <= `HS_RST_IRQ_MASK;
    end else if (wr_en) begin
      case (paddr)
        `HS_OFF_PART_LENGTH: part_length <= pwdata[DW-1:0];
        `HS_OFF_HOLE_TARGET: hole_target <= pwdata[CW-1:0];
        `HS_OFF_CUT_OFFSET: cut_offset <= pwdata[DW-1:0];
        `HS_OFF_SHEAR_DET: shear_det <= pwdata[DW-1:0];
        `HS_OFF_MIN_SPACING: min_spacing <= pwdata[DW-1:0];
        `HS_OFF_NO_HOLE_STOP: no_hole_stop <= pwdata[DW-1:0];
        `HS_OFF_PART_QUANTITY: part_quantity <= pwdata[CW-1:0];
        `HS_OFF_IRQ_MASK: irq_mask <= pwdata[`HS_EVT_COUNT-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // hole detection and qualification
  // ------------------------------------------------------------
  logic hole_onset;
  logic lockout;
  logic hole_count_en;
  logic holes_reached;
  logic step;

  hole_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .hole_in(hole_in),
    .pol(pol),
    .hole_onset(hole_onset)
  );

  // travel only counts while the line is commanded to run
  assign step = enc_step & (state == hole_shear_pkg::ST_RUN);

  // a second edge inside the spacing window is the same hole seen again
  assign lockout = hole_seen & (dist_since_hole < min_spacing);
  assign holes_reached = (holes >= hole_target);
  assign hole_count_en = hole_onset & (state == hole_shear_pkg::ST_RUN)
                         & (mode == hole_shear_pkg::MODE_HOLE) & ~lockout & ~holes_reached;

  // ------------------------------------------------------------
  // cut point and missing-hole check
  // ------------------------------------------------------------
  logic [DW:0] hole_cut_dist;
  logic [DW:0] missing_len;
  logic cut_point;
  logic missing_hole;
  logic last_part;

  // the last hole reaches the blade after the detector distance, then offset
  assign hole_cut_dist = {1'b0, shear_det} + {1'b0, cut_offset};
  assign missing_len = {1'b0, pos_since_cut} + {1'b0, shear_det};

  always_comb begin
    if (mode == hole_shear_pkg::MODE_HOLE) begin
      cut_point = holes_reached & hole_seen & ({1'b0, dist_since_hole} >= hole_cut_dist);
    end else begin
      cut_point = (pos_since_cut >= part_length);
    end
  end

  // hole_target of zero never trips: there is nothing to wait for
  assign missing_hole = (mode == hole_shear_pkg::MODE_HOLE) & ~holes_reached
                        & (missing_len > {1'b0, no_hole_stop});
  assign last_part = (parts + {{(CW-1){1'b0}}, 1'b1}) >= part_quantity;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // fault has priority over a cut found in the same cycle
  always_comb begin
    next_state = state;
    case (state)
      hole_shear_pkg::ST_IDLE: begin
        if (start_pulse && part_quantity != '0) begin
          next_state = hole_shear_pkg::ST_RUN;
        end
      end
      hole_shear_pkg::ST_RUN: begin
        if (stop_pulse) begin
          next_state = hole_shear_pkg::ST_IDLE;
        end else if (missing_hole) begin
          next_state = hole_shear_pkg::ST_FAULT;
        end else if (cut_point) begin
          next_state = hole_shear_pkg::ST_SHEAR;
        end
      end
      hole_shear_pkg::ST_SHEAR: begin
        if (shear_done) begin
          next_state = (last_part || stop_pulse) ? hole_shear_pkg::ST_IDLE : hole_shear_pkg::ST_RUN;
        end
      end
      hole_shear_pkg::ST_FAULT: begin
        if (clr_fault_pulse) begin
          next_state = hole_shear_pkg::ST_IDLE;
        end
      end
      default: next_state = hole_shear_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= hole_shear_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // line drive and press request as registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_run <= 1'b0;
      shear_req <= 1'b0;
    end else begin
      line_run <= (next_state == hole_shear_pkg::ST_RUN);
      shear_req <= (next_state == hole_shear_pkg::ST_SHEAR);
    end
  end

  // fault holds until software clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault <= 1'b0;
    end else if (state == hole_shear_pkg::ST_RUN && next_state == hole_shear_pkg::ST_FAULT) begin
      fault <= 1'b1;
    end else if (clr_fault_pulse) begin
      fault <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // position tracking
  // ------------------------------------------------------------
  logic cut_finish;
  assign cut_finish = (state == hole_shear_pkg::ST_SHEAR) & shear_done;

  // counters saturate rather than wrap, so a long run cannot fake a short one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_since_cut <= '0;
    end else if (cut_finish || start_pulse) begin
      pos_since_cut <= '0;
    end else if (step && pos_since_cut != '1) begin
      pos_since_cut <= pos_since_cut + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dist_since_hole <= '0;
      hole_seen <= 1'b0;
    end else if (cut_finish || start_pulse) begin
      dist_since_hole <= '0;
      hole_seen <= 1'b0;
    end else if (hole_count_en) begin
      dist_since_hole <= '0;
      hole_seen <= 1'b1;
    end else if (step && dist_since_hole != '1) begin
      dist_since_hole <= dist_since_hole + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  // ------------------------------------------------------------
  // hole and part counters
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holes <= '0;
    end else if (cut_finish || start_pulse) begin
      holes <= '0;
    end else if (hole_count_en) begin
      holes <= holes + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parts <= '0;
    end else if (start_pulse && state == hole_shear_pkg::ST_IDLE) begin
      parts <= '0;
    end else if (cut_finish) begin
      parts <= parts + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ------------------------------------------------------------
  // interrupt events
  // ------------------------------------------------------------
  assign evt_set[`HS_EVT_CUT_BIT] = cut_finish;
  assign evt_set[`HS_EVT_MISSING_BIT] = (state == hole_shear_pkg::ST_RUN)
                                        & (next_state == hole_shear_pkg::ST_FAULT);
  assign evt_set[`HS_EVT_ORDER_DONE_BIT] = cut_finish & last_part;

  genvar gi;
  generate
    for (gi = 0; gi < `HS_EVT_COUNT; gi++) begin : g_evt
      sticky_event u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .set(evt_set[gi]),
        .clr(irq_rd_clr),
        .flag(irq_status[gi])
      );
    end
  endgenerate

  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `HS_OFF_CTRL: begin
        rd_mux[`HS_CTRL_MODE_BIT] = mode;
        rd_mux[`HS_CTRL_POL_BIT] = pol;
      end
      `HS_OFF_PART_LENGTH: rd_mux[DW-1:0] = part_length;
      `HS_OFF_HOLE_TARGET: rd_mux[CW-1:0] = hole_target;
      `HS_OFF_CUT_OFFSET: rd_mux[DW-1:0] = cut_offset;
      `HS_OFF_SHEAR_DET: rd_mux[DW-1:0] = shear_det;
      `HS_OFF_MIN_SPACING: rd_mux[DW-1:0] = min_spacing;
      `HS_OFF_NO_HOLE_STOP: rd_mux[DW-1:0] = no_hole_stop;
      `HS_OFF_PART_QUANTITY: rd_mux[CW-1:0] = part_quantity;
      `HS_OFF_STATUS: begin
        rd_mux[`HS_STAT_STATE_LSB +: 3] = state;
        rd_mux[`HS_STAT_FAULT_BIT] = fault;
        rd_mux[`HS_STAT_HOLES_LSB +: 8] = holes[7:0];
        rd_mux[`HS_STAT_PARTS_LSB +: CW] = parts;
      end
      `HS_OFF_IRQ_STATUS: rd_mux[`HS_EVT_COUNT-1:0] = irq_status;
      `HS_OFF_IRQ_MASK: rd_mux[`HS_EVT_COUNT-1:0] = irq_mask;
      `HS_OFF_POSITION: rd_mux[DW-1:0] = pos_since_cut;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // sampled in the setup cycle so the access cycle sees a flopped value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

/* core/hole_shear_defines.svh */
`ifndef HOLE_SHEAR_DEFINES_SVH
`define HOLE_SHEAR_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define HS_OFF_CTRL 12'h000
`define HS_OFF_PART_LENGTH 12'h004
`define HS_OFF_HOLE_TARGET 12'h008
`define HS_OFF_CUT_OFFSET 12'h00c
`define HS_OFF_SHEAR_DET 12'h010
`define HS_OFF_MIN_SPACING 12'h014
`define HS_OFF_NO_HOLE_STOP 12'h018
`define HS_OFF_PART_QUANTITY 12'h01c
`define HS_OFF_STATUS 12'h020
`define HS_OFF_IRQ_STATUS 12'h024
`define HS_OFF_IRQ_MASK 12'h028
`define HS_OFF_POSITION 12'h02c

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define HS_CTRL_MODE_BIT 0
`define HS_CTRL_POL_BIT 1
`define HS_CTRL_START_BIT 2
`define HS_CTRL_STOP_BIT 3
`define HS_CTRL_CLR_FAULT_BIT 4

// ------------------------------------------------------------
// event bits, shared by irq status and irq mask
// ------------------------------------------------------------
`define HS_EVT_CUT_BIT 0
`define HS_EVT_MISSING_BIT 1
`define HS_EVT_ORDER_DONE_BIT 2
`define HS_EVT_COUNT 3

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define HS_STAT_STATE_LSB 0
`define HS_STAT_FAULT_BIT 3
`define HS_STAT_HOLES_LSB 8
`define HS_STAT_PARTS_LSB 16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define HS_RST_MODE 1'b0
`define HS_RST_POL 1'b0
`define HS_RST_IRQ_MASK 3'h0

`endif

/* core/hole_shear_pkg.sv */
package hole_shear_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_SHEAR = 3'b010,
    ST_FAULT = 3'b011
  } line_state_t;

  typedef enum logic {
    MODE_STANDARD = 1'b0,
    MODE_HOLE     = 1'b1
  } cut_mode_t;

  typedef enum logic {
    POL_ACTIVE_LOW  = 1'b0,
    POL_ACTIVE_HIGH = 1'b1
  } hole_pol_t;

endpackage

/* core/hole_edge_detect.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// hole input polarity and onset detection
// ------------------------------------------------------------
module hole_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hole_in,
  input wire hole_shear_pkg::hole_pol_t pol,
  output logic hole_onset
);

  logic active;
  logic active_q;

  // active-low counts the input tied to common
  assign active = (pol == hole_shear_pkg::POL_ACTIVE_HIGH) ? hole_in : ~hole_in;

  // previous level; reset as inactive so a held level at start is one hole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active;
    end
  end

  assign hole_onset = active & ~active_q;

endmodule

/* core/sticky_event.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// sticky event bit, cleared by a read, set beats clear
// ------------------------------------------------------------
module sticky_event (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  // set tested first so a same-cycle event is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule

/* dv/hole_shear_sva.sv */
`timescale 1ns/1ps
// ------------
// port checker
// ------------
module hole_shear_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enc_step,
  input wire logic shear_done,
  input wire logic line_run,
  input wire logic shear_req,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase shapes
  sequence bad_s;
    psel && penable && paddr > 12'h02c;
  endsequence
  sequence stop_s;
    psel && penable && pwrite && paddr == 12'h000 && pwdata[3];
  endsequence
  // event sources quiet now and one cycle back, so no new set can race the clear;
  // a cut finished last cycle may raise a missing event on the first run cycle
  sequence irq_rd_s;
    psel && penable && !pwrite && paddr == 12'h024 && !enc_step && !$past(enc_step)
    && !shear_done && !$past(shear_done);
  endsequence
  AST_READY: assert property (psel && penable |-> pready) else $error("pready low");
  AST_BAD: assert property (bad_s |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad access");
  AST_EXCL: assert property (!(line_run && shear_req)) else $error("runs in cut");
  AST_HOLD: assert property (shear_req && !shear_done |=> shear_req) else $error("cut dropped");
  AST_END: assert property (shear_req && shear_done |=> !shear_req) else $error("cut stuck");
  AST_FROM_RUN: assert property ($rose(shear_req) |-> $past(line_run)) else $error("cut idle");
  AST_STOP: assert property (stop_s |=> !line_run) else $error("stop ignored");
  AST_IRQ_CLR: assert property (irq_rd_s |=> !irq) else $error("irq kept");
endmodule

bind hole_count_shear_trigger hole_shear_sva u_hole_shear_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .enc_step, .shear_done, .line_run, .shear_req, .irq
);

/* dv/hole_line_model.sv */
`timescale 1ns/1ps
// ------------
// detector, encoder and press
// ------------
module hole_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_run,
  input wire logic shear_req,
  input wire logic pol,
  input wire logic holes_on,
  input wire logic clear_pos,
  input wire logic [7:0] pitch,
  output logic hole_in,
  output logic enc_step,
  output logic shear_done,
  output int pos
);
  int div;
  int sd;
  int ph;
  // bouncy hole: active, gap, active, so one hole shows two edges
  assign ph = pos % int'(pitch);
  assign hole_in = (holes_on && (ph == 5 || ph == 7)) ~^ pol;
  // step every sixth cycle while moving; press answers a few cycles late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 0;
      enc_step <= 1'b0;
      pos <= 0;
      sd <= 0;
      shear_done <= 1'b0;
    end else begin
      div <= (line_run && div < 5) ? div + 1 : 0;
      enc_step <= line_run && div == 5;
      pos <= clear_pos ? 0 : pos + int'(enc_step);
      sd <= shear_req ? (sd < 4 ? sd + 1 : sd) : 0;
      shear_done <= shear_req && sd == 3;
    end
  end
endmodule

/* dv/hole_count_shear_trigger_test.sv */
`timescale 1ns/1ps
// ------------
// bench top
// ------------
module hole_count_shear_trigger_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic hole_in, enc_step, shear_done, line_run, shear_req, irq, pol, holes_on, clear_pos;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, seed;
  logic [7:0] pitch;
  logic [1:0] obs;
  int pos, err_count, compares, t, o, n, len;
  assign obs = {line_run, shear_req};
  hole_count_shear_trigger u_hole_count_shear_trigger (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .hole_in, .enc_step, .shear_done, .line_run, .shear_req, .irq
  );
  hole_line_model u_hole_line_model (
    .pclk, .presetn, .line_run, .shear_req, .pol, .holes_on, .clear_pos, .pitch,
    .hole_in, .enc_step, .shear_done, .pos
  );
  // 50 mhz
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // xorshift, fixed seed keeps runs repeatable
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task timeout();
    check("wait done", 32'h0, 32'h1);
    final_report();
  endtask
  // poll at edges: values seen are those the edge sampled
  task wait_obs(input int s, input logic lvl);
    int k;
    for (k = 0; obs[s] !== lvl && k < 20000; k++) @(posedge pclk);
    if (k == 20000) timeout();
  endtask
  // one apb transfer; idle cycle after it so no signal is set twice in a step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 0; pready !== 1'b1 && k < 50; k++) @(posedge pclk);
    if (k == 50) timeout();
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // program a job, zero the line position, start
  task setup(input logic m, input logic p, input logic [31:0] v[7]);
    for (int i = 0; i < 7; i++) apb(1'b1, 12'(4 * i + 4), v[i]);
    clear_pos <= 1'b1;
    @(posedge pclk);
    clear_pos <= 1'b0;
    pol <= p;
    apb(1'b1, 12'h000, {29'h0, 1'b1, p, m});
  endtask
  initial begin
    {psel, penable, pwrite, pol, clear_pos, presetn} = 6'h0;
    {paddr, pwdata, pitch} = 52'h0;
    pitch = 8'h10;
    holes_on = 1'b1;
    seed = 32'hcdf3870e;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and decode
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl mode pol", rdv & 32'h3, 32'h0);
    check("ctrl err", 32'(last_err), 32'h0);
    apb(1'b0, 12'h028, 32'h0);
    check("irq mask", rdv, 32'h0);
    apb(1'b1, 12'h030, 32'h5);
    check("unmapped wr err", 32'(last_err), 32'h1);
    apb(1'b0, 12'h030, 32'h0);
    check("unmapped rd", {rdv[30:0], last_err}, 32'h1);
    apb(1'b1, 12'h028, 32'h7);
    $display("test registers finished");
    // hole mode, both polarities; spacing 3 hides the bounce
    for (int p = 0; p < 2; p++) begin
      pitch <= 8'(14 + xs() % 4);
      t = 2 + xs() % 4;
      o = 1 + xs() % 3;
      setup(1'b1, p[0], '{32'h0, t, o, 10, 3, 32'hffff, 2});
      for (int k = 1; k <= 2; k++) begin
        wait_obs(0, 1'b1);
        check("cut pos", pos, (k * t - 1) * pitch + 15 + o);
        wait_obs(0, 1'b0);
      end
      wait_obs(1, 1'b0);
      apb(1'b0, 12'h020, 32'h0);
      check("status", rdv, 32'h20000);
      apb(1'b0, 12'h02c, 32'h0);
      check("position", rdv, 32'h0);
      check("irq set", 32'(irq), 32'h1);
      apb(1'b0, 12'h024, 32'h0);
      check("events", rdv, 32'h5);
      check("irq clear", 32'(irq), 32'h0);
      $display("test hole mode %0d finished", p);
    end
    // standard mode ignores holes; stop mid order
    len = 5 + xs() % 16;
    setup(1'b0, 1'b0, '{len, 2, 1, 10, 3, 32'hffff, 2});
    wait_obs(0, 1'b1);
    check("length cut", pos, len);
    wait_obs(0, 1'b0);
    wait_obs(1, 1'b1);
    apb(1'b1, 12'h000, 32'h8);
    check("stopped", 32'(line_run), 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("parts", rdv, 32'h10000);
    apb(1'b0, 12'h024, 32'h0);
    check("cut event", rdv, 32'h1);
    $display("test standard mode finished");
    // dead detector must stop the line
    holes_on <= 1'b0;
    n = 20 + xs() % 21;
    setup(1'b1, 1'b0, '{32'h0, 3, 1, 10, 3, n, 1});
    wait_obs(1, 1'b0);
    check("fault pos", pos, n - 9);
    apb(1'b0, 12'h020, 32'h0);
    check("fault status", rdv, 32'hb);
    apb(1'b0, 12'h024, 32'h0);
    check("missing event", rdv, 32'h2);
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b0, 12'h020, 32'h0);
    check("fault cleared", rdv, 32'h0);
    $display("test missing hole finished");
    final_report();
  end
endmodule
